// [rtl/upd_top.sv]
// Uptime counters and user program mapping tables behind an Avalon slave.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module upd_top #(
  parameter int TICK_CYCLES = upd_pkg::TICK_CYCLES
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   SRST_IN,
  input  wire logic [upd_pkg::ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic                   AVS_READ_IN,
  input  wire logic                   AVS_WRITE_IN,
  input  wire logic [31:0]            AVS_WRITEDATA_IN,
  output logic      [31:0]            AVS_READDATA_OUT,
  output logic                        AVS_WAITREQUEST_OUT,
  input  wire logic                   LOAD_WE_IN,
  input  wire upd_pkg::upd_mem_addr_t LOAD_ADDR_IN,
  input  wire upd_pkg::upd_map_entry_t LOAD_DATA_IN,
  input  wire logic                   PRE_RUN_IN,
  input  wire logic                   POST_RUN_IN,
  input  wire logic                   XFER_ACK_IN,
  output logic                        XFER_REQ_OUT,
  output logic                        XFER_DIR_OUT,
  output logic      [4:0]             XFER_SLOT_OUT,
  output upd_pkg::upd_map_entry_t     XFER_ENTRY_OUT,
  output logic                        COPY_BUSY_OUT,
  output logic                        COPY_DONE_OUT,
  output logic      [31:0]            UPTIME_SECONDS_OUT
);

  import upd_pkg::*;

  // Counter widths follow the divider lengths.
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int SEC_W  = $clog2(TICKS_PER_SECOND + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [SEC_W-1:0]  SEC_LAST  = SEC_W'(TICKS_PER_SECOND - 1);

  logic [TICK_W-1:0] tick_div_reg;
  logic              ms_tick_reg;
  logic [SEC_W-1:0]  sec_div_reg;
  logic [31:0]       uptime_ms_reg;
  logic [31:0]       uptime_s_reg;

  upd_bus_state_t    bus_state_reg;
  logic [15:0]       bus_index_reg;
  logic [7:0]        bus_sub_reg;
  logic              bus_is_read_reg;
  logic              bus_grant;
  logic [2:0]        bus_tbl;
  upd_mem_addr_t     bus_maddr;
  logic [2:0]        reg_tbl;

  upd_seq_state_t    seq_state_reg;
  logic              seq_pass_reg;
  logic [3:0]        seq_slot_reg;
  logic [1:0]        seq_first_tbl_reg;
  logic [1:0]        seq_tbl;
  upd_mem_addr_t     seq_maddr;

  upd_mem_addr_t     mem_raddr;
  logic [31:0]       mem_rdata;
  logic              mem_we;
  upd_map_entry_t    fetched;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Returns a hit flag above the table select for a table object index.
  function automatic logic [2:0] decode_table(input logic [15:0] index);
    logic [2:0] res;
    res = {1'b0, TBL_NONE};
    if (index == OBJ_INPUT_SEL) begin
      res = {1'b1, TBL_INPUT};
    end else if (index == OBJ_OUTPUT_SEL) begin
      res = {1'b1, TBL_OUTPUT};
    end else if (index == OBJ_BIDIR_SEL) begin
      res = {1'b1, TBL_BIDIR};
    end
    return res;
  endfunction

  // Tells whether a subindex names one of the sixteen mapping entries.
  function automatic logic is_entry_sub(input logic [7:0] sub);
    return (sub != SUB_COUNT) && (sub <= SUB_LAST_ENTRY);
  endfunction

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      tick_div_reg <= '0;
      ms_tick_reg  <= 1'b0;
    end else if (tick_div_reg == TICK_LAST) begin
      tick_div_reg <= '0;
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_div_reg <= tick_div_reg + 1'b1;
      ms_tick_reg  <= 1'b0;
    end
  end

  // ****************************************************************
  // Uptime counters
  // ****************************************************************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      uptime_ms_reg <= UPTIME_RESET;
    end else if (ms_tick_reg) begin
      uptime_ms_reg <= uptime_ms_reg + 32'h00000001;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      sec_div_reg  <= '0;
      uptime_s_reg <= UPTIME_RESET;
    end else if (ms_tick_reg) begin
      if (sec_div_reg == SEC_LAST) begin
        sec_div_reg  <= '0;
        uptime_s_reg <= uptime_s_reg + 32'h00000001;
      end else begin
        sec_div_reg <= sec_div_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      UPTIME_SECONDS_OUT <= UPTIME_RESET;
    end else begin
      UPTIME_SECONDS_OUT <= uptime_s_reg;
    end
  end

  // ****************************************************************
  // Table memory
  // ****************************************************************
  // The loader may write any slot of the three tables.
  assign mem_we = LOAD_WE_IN && (LOAD_ADDR_IN.table_sel != TBL_NONE);

  always_comb begin
    bus_tbl   = decode_table(AVS_ADDRESS_IN[ADDR_INDEX_LSB +: 16]);
    reg_tbl   = decode_table(bus_index_reg);
    bus_maddr.table_sel = bus_tbl[1:0];
    bus_maddr.slot = 4'(AVS_ADDRESS_IN[ADDR_SUB_LSB +: 8] - 8'h01);
    seq_tbl   = seq_pass_reg ? TBL_BIDIR : seq_first_tbl_reg;
    seq_maddr.table_sel = seq_tbl;
    seq_maddr.slot = seq_slot_reg;
    mem_raddr = (seq_state_reg == SEQ_FETCH) ? seq_maddr : bus_maddr;
  end

  // Only the program loader fills the tables; the bus has no path in.
  upd_map_mem #(
    .DW    (MEM_DW),
    .AW    (MEM_AW),
    .DEPTH (MEM_DEPTH)
  ) u_map_mem (
    .clk_in    (CLK_IN),
    .srst_in   (SRST_IN),
    .we_in     (mem_we),
    .waddr_in  (LOAD_ADDR_IN),
    .wdata_in  (LOAD_DATA_IN),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  // ****************************************************************
  // Avalon slave
  // ****************************************************************
  // An access is taken only while the sequencer leaves the memory free.
  assign bus_grant = (bus_state_reg == BUS_IDLE)
                     && (AVS_READ_IN || AVS_WRITE_IN)
                     && (seq_state_reg != SEQ_FETCH);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      bus_state_reg       <= BUS_IDLE;
      bus_index_reg       <= '0;
      bus_sub_reg         <= '0;
      bus_is_read_reg     <= 1'b0;
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      unique case (bus_state_reg)
        BUS_IDLE: begin
          if (bus_grant) begin
            bus_index_reg   <= AVS_ADDRESS_IN[ADDR_INDEX_LSB +: 16];
            bus_sub_reg     <= AVS_ADDRESS_IN[ADDR_SUB_LSB +: 8];
            bus_is_read_reg <= AVS_READ_IN;
            bus_state_reg   <= BUS_WAIT;
          end
        end
        BUS_WAIT: begin
          AVS_WAITREQUEST_OUT <= 1'b0;
          bus_state_reg       <= BUS_DONE;
        end
        BUS_DONE: begin
          AVS_WAITREQUEST_OUT <= 1'b1;
          bus_state_reg       <= BUS_IDLE;
        end
        default: begin
          AVS_WAITREQUEST_OUT <= 1'b1;
          bus_state_reg       <= BUS_IDLE;
        end
      endcase
    end
  end

  // Writes are answered and dropped; every object here is read only.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      AVS_READDATA_OUT <= READ_ZERO;
    end else if ((bus_state_reg == BUS_WAIT) && bus_is_read_reg) begin
      if (bus_index_reg == OBJ_UPTIME_MS) begin
        if (bus_sub_reg == SUB_COUNT) begin
          AVS_READDATA_OUT <= MS_OBJ_COUNT;
        end else if (bus_sub_reg == SUB_MS_VALUE) begin
          AVS_READDATA_OUT <= uptime_ms_reg;
        end else begin
          AVS_READDATA_OUT <= READ_ZERO;
        end
      end else if (bus_index_reg == OBJ_UPTIME_S) begin
        if (bus_sub_reg == SUB_COUNT) begin
          AVS_READDATA_OUT <= uptime_s_reg;
        end else begin
          AVS_READDATA_OUT <= READ_ZERO;
        end
      end else if (reg_tbl[2]) begin
        if (bus_sub_reg == SUB_COUNT) begin
          AVS_READDATA_OUT <= TABLE_COUNT;
        end else if (is_entry_sub(bus_sub_reg)) begin
          AVS_READDATA_OUT <= mem_rdata;
        end else begin
          AVS_READDATA_OUT <= READ_ZERO;
        end
      end else begin
        AVS_READDATA_OUT <= READ_ZERO;
      end
    end
  end

  // ****************************************************************
  // Copy sequencer
  // ****************************************************************
  // Walks the first table, then the bidirectional table, slot by slot.
  assign fetched = upd_map_entry_t'(mem_rdata);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      seq_state_reg     <= SEQ_IDLE;
      seq_pass_reg      <= 1'b0;
      seq_slot_reg      <= '0;
      seq_first_tbl_reg <= TBL_INPUT;
      XFER_REQ_OUT      <= 1'b0;
      XFER_DIR_OUT      <= DIR_TO_IMAGE;
      XFER_SLOT_OUT     <= '0;
      XFER_ENTRY_OUT    <= '0;
      COPY_BUSY_OUT     <= 1'b0;
      COPY_DONE_OUT     <= 1'b0;
    end else begin
      COPY_DONE_OUT <= 1'b0;
      unique case (seq_state_reg)
        SEQ_IDLE: begin
          seq_pass_reg <= 1'b0;
          seq_slot_reg <= '0;
          if (PRE_RUN_IN) begin
            seq_first_tbl_reg <= TBL_INPUT;
            XFER_DIR_OUT      <= DIR_TO_IMAGE;
            COPY_BUSY_OUT     <= 1'b1;
            seq_state_reg     <= SEQ_FETCH;
          end else if (POST_RUN_IN) begin
            seq_first_tbl_reg <= TBL_OUTPUT;
            XFER_DIR_OUT      <= DIR_FROM_IMAGE;
            COPY_BUSY_OUT     <= 1'b1;
            seq_state_reg     <= SEQ_FETCH;
          end
        end
        SEQ_FETCH: begin
          seq_state_reg <= SEQ_LOOK;
        end
        SEQ_LOOK: begin
          XFER_ENTRY_OUT <= fetched;
          XFER_SLOT_OUT  <= {seq_pass_reg, seq_slot_reg};
          if (fetched.index != 16'h0000) begin
            XFER_REQ_OUT  <= 1'b1;
            seq_state_reg <= SEQ_XFER;
          end else if (seq_slot_reg != SLOT_LAST) begin
            seq_slot_reg  <= seq_slot_reg + 4'h1;
            seq_state_reg <= SEQ_FETCH;
          end else if (!seq_pass_reg) begin
            seq_pass_reg  <= 1'b1;
            seq_slot_reg  <= '0;
            seq_state_reg <= SEQ_FETCH;
          end else begin
            seq_state_reg <= SEQ_DONE;
          end
        end
        SEQ_XFER: begin
          if (XFER_ACK_IN) begin
            XFER_REQ_OUT <= 1'b0;
            if (seq_slot_reg != SLOT_LAST) begin
              seq_slot_reg  <= seq_slot_reg + 4'h1;
              seq_state_reg <= SEQ_FETCH;
            end else if (!seq_pass_reg) begin
              seq_pass_reg  <= 1'b1;
              seq_slot_reg  <= '0;
              seq_state_reg <= SEQ_FETCH;
            end else begin
              seq_state_reg <= SEQ_DONE;
            end
          end
        end
        SEQ_DONE: begin
          COPY_BUSY_OUT <= 1'b0;
          COPY_DONE_OUT <= 1'b1;
          seq_state_reg <= SEQ_IDLE;
        end
        default: begin
          XFER_REQ_OUT  <= 1'b0;
          COPY_BUSY_OUT <= 1'b0;
          seq_state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

endmodule

// [rtl/upd_pkg.sv]
// Constants, field layouts and types shared by the uptime and mapping block.
package upd_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ      = 20_000_000;
  localparam int TICK_PERIOD_MS   = 1;
  localparam int TICK_CYCLES      = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TICKS_PER_SECOND = 1000;

  // ****************************************************************
  // Object indexes, subindexes and fixed values
  // ****************************************************************
  localparam logic [15:0] OBJ_UPTIME_MS   = 16'h230E;
  localparam logic [15:0] OBJ_UPTIME_S    = 16'h230F;
  localparam logic [15:0] OBJ_INPUT_SEL   = 16'h2310;
  localparam logic [15:0] OBJ_OUTPUT_SEL  = 16'h2320;
  localparam logic [15:0] OBJ_BIDIR_SEL   = 16'h2330;
  localparam logic [7:0]  SUB_COUNT       = 8'h00;
  localparam logic [7:0]  SUB_MS_VALUE    = 8'h01;
  localparam logic [7:0]  SUB_LAST_ENTRY  = 8'h10;
  localparam logic [31:0] MS_OBJ_COUNT    = 32'h00000001;
  localparam logic [31:0] TABLE_COUNT     = 32'h00000010;
  localparam logic [31:0] UPTIME_RESET    = 32'h00000000;
  localparam logic [31:0] READ_ZERO       = 32'h00000000;

  // ****************************************************************
  // Bus address layout: byte address = (index * 256 + subindex) * 4
  // ****************************************************************
  localparam int ADDR_W         = 26;
  localparam int ADDR_INDEX_LSB = 10;
  localparam int ADDR_SUB_LSB   = 2;

  // ****************************************************************
  // Table storage
  // ****************************************************************
  localparam int         TABLE_SLOTS = 16;
  localparam int         MEM_AW      = 6;
  localparam int         MEM_DEPTH   = 48;
  localparam int         MEM_DW      = 32;
  localparam logic [1:0] TBL_INPUT   = 2'h0;
  localparam logic [1:0] TBL_OUTPUT  = 2'h1;
  localparam logic [1:0] TBL_BIDIR   = 2'h2;
  localparam logic [1:0] TBL_NONE    = 2'h3;
  localparam logic [3:0] SLOT_LAST   = 4'hF;
  localparam logic       DIR_TO_IMAGE   = 1'b0;
  localparam logic       DIR_FROM_IMAGE = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [7:0]  length;
  } upd_map_entry_t;

  typedef struct packed {
    logic [1:0] table_sel;
    logic [3:0] slot;
  } upd_mem_addr_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_DONE = 2'b10
  } upd_bus_state_t;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_FETCH = 3'b001,
    SEQ_LOOK  = 3'b010,
    SEQ_XFER  = 3'b011,
    SEQ_DONE  = 3'b100
  } upd_seq_state_t;

endpackage

// [rtl/upd_map_mem.sv]
// Small table memory with one write port and a registered read port.
`timescale 1ns/100ps
module upd_map_mem #(
  parameter int DW    = 32,
  parameter int AW    = 6,
  parameter int DEPTH = 48
) (
  input  wire logic          clk_in,
  input  wire logic          srst_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_reg [DEPTH];

  // ****************************************************************
  // Storage, cleared words are not held over a power cycle.
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (we_in && (int'(waddr_in) < DEPTH)) begin
      mem_reg[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else if (int'(raddr_in) < DEPTH) begin
      rdata_out <= mem_reg[raddr_in];
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

// [testbench/upd_xfer_model.sv]
// Image side responder that acknowledges each copy request.
`timescale 1ns/100ps
module upd_xfer_model (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic req_in,
  output logic      ack_out
);
  logic [1:0] cnt_reg;
  logic       slow_reg;
  // ****************************************************************
  // Answers alternate between prompt and three stalled cycles.
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg  <= 2'h0;
      ack_out  <= 1'b0;
      slow_reg <= 1'b0;
    end else if (!req_in || ack_out) begin
      cnt_reg <= 2'h0;
      ack_out <= 1'b0;
    end else if (cnt_reg == {slow_reg, slow_reg}) begin
      ack_out  <= 1'b1;
      slow_reg <= ~slow_reg;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
endmodule

// [testbench/upd_top_chk.sv]
// Port checker for the uptime and mapping block.
`timescale 1ns/100ps
module upd_top_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                    CLK_IN,
  input wire logic                    SRST_IN,
  input wire logic                    AVS_READ_IN,
  input wire logic                    AVS_WRITE_IN,
  input wire logic                    AVS_WAITREQUEST_OUT,
  input wire logic                    PRE_RUN_IN,
  input wire logic                    POST_RUN_IN,
  input wire logic                    XFER_ACK_IN,
  input wire logic                    XFER_REQ_OUT,
  input wire logic                    XFER_DIR_OUT,
  input wire logic [4:0]              XFER_SLOT_OUT,
  input wire upd_pkg::upd_map_entry_t XFER_ENTRY_OUT,
  input wire logic                    COPY_BUSY_OUT,
  input wire logic                    COPY_DONE_OUT,
  input wire logic [31:0]             UPTIME_SECONDS_OUT
);
  import upd_pkg::*;
  localparam int SEC_LO = TICK_CYCLES * 1000 - 4;
  localparam int SEC_HI = TICK_CYCLES * 1000 + 4;
  logic        dir_reg;
  logic [31:0] sec_reg;
  logic [15:0] gap_reg;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // ****************************************************************
  // Helper state: pass direction and cycles between seconds steps.
  // ****************************************************************
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      dir_reg <= DIR_TO_IMAGE;
    end else if (!COPY_BUSY_OUT && PRE_RUN_IN) begin
      dir_reg <= DIR_TO_IMAGE;
    end else if (!COPY_BUSY_OUT && POST_RUN_IN) begin
      dir_reg <= DIR_FROM_IMAGE;
    end
  end
  always_ff @(posedge CLK_IN) begin
    sec_reg <= UPTIME_SECONDS_OUT;
    if (SRST_IN || UPTIME_SECONDS_OUT != sec_reg) begin
      gap_reg <= 16'h0000;
    end else begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end
  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_reset_idle: assert property (disable iff (1'b0) SRST_IN |=>
    AVS_WAITREQUEST_OUT && !XFER_REQ_OUT && !COPY_BUSY_OUT &&
    UPTIME_SECONDS_OUT == 32'h00000000)
    else $error("outputs not idle after reset");
  a_read_answer: assert property ($rose(AVS_READ_IN) |->
    ##[2:6] !AVS_WAITREQUEST_OUT) else $error("read not answered");
  a_wait_cause: assert property (!AVS_WAITREQUEST_OUT |->
    ($past(AVS_READ_IN) || $past(AVS_WRITE_IN)) ##1 AVS_WAITREQUEST_OUT)
    else $error("waitrequest low without access");
  a_sec_step: assert property ($changed(UPTIME_SECONDS_OUT) &&
    !$past(SRST_IN) |-> UPTIME_SECONDS_OUT == $past(UPTIME_SECONDS_OUT)
    + 32'h00000001) else $error("seconds did not step by one");
  a_sec_period: assert property ($changed(UPTIME_SECONDS_OUT) &&
    !$past(SRST_IN) |-> gap_reg inside {[SEC_LO:SEC_HI]})
    else $error("seconds step not one thousand ticks");
  a_busy_start: assert property ((PRE_RUN_IN || POST_RUN_IN) &&
    !COPY_BUSY_OUT |=> COPY_BUSY_OUT)
    else $error("copy did not start");
  a_req_hold: assert property (XFER_REQ_OUT && !XFER_ACK_IN |=>
    XFER_REQ_OUT && $stable(XFER_ENTRY_OUT) && $stable(XFER_SLOT_OUT)
    && $stable(XFER_DIR_OUT)) else $error("request changed early");
  a_req_drop: assert property (XFER_REQ_OUT && XFER_ACK_IN |=>
    !XFER_REQ_OUT) else $error("request held after ack");
  a_req_valid: assert property (XFER_REQ_OUT |-> COPY_BUSY_OUT &&
    XFER_ENTRY_OUT.index != 16'h0000 && XFER_DIR_OUT == dir_reg)
    else $error("bad request direction or entry");
  a_done_end: assert property (COPY_DONE_OUT |->
    (!COPY_BUSY_OUT && $past(COPY_BUSY_OUT)) ##1 !COPY_DONE_OUT)
    else $error("done pulse malformed");
  c_pre: cover property (COPY_DONE_OUT && dir_reg == DIR_TO_IMAGE);
  c_post: cover property (COPY_DONE_OUT && dir_reg == DIR_FROM_IMAGE);
  c_write: cover property (!AVS_WAITREQUEST_OUT && AVS_WRITE_IN);
  c_sec: cover property ($changed(UPTIME_SECONDS_OUT));
endmodule
bind upd_top upd_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .PRE_RUN_IN(PRE_RUN_IN), .POST_RUN_IN(POST_RUN_IN),
  .XFER_ACK_IN(XFER_ACK_IN), .XFER_REQ_OUT(XFER_REQ_OUT),
  .XFER_DIR_OUT(XFER_DIR_OUT), .XFER_SLOT_OUT(XFER_SLOT_OUT),
  .XFER_ENTRY_OUT(XFER_ENTRY_OUT), .COPY_BUSY_OUT(COPY_BUSY_OUT),
  .COPY_DONE_OUT(COPY_DONE_OUT), .UPTIME_SECONDS_OUT(UPTIME_SECONDS_OUT));

// [testbench/testbench.sv]
// Self-checking bench for the uptime and mapping block.
`timescale 1ns/100ps
module testbench;
  import upd_pkg::*;
  localparam logic [31:0] E_IN  = 32'h230F0020;
  localparam logic [31:0] E_OUT = 32'h25000120;
  localparam logic [31:0] E_BI  = 32'h24000210;
  logic              clk     = 1'b0;
  logic              srst    = 1'b1;
  logic [ADDR_W-1:0] addr    = '0;
  logic              rd      = 1'b0;
  logic              wr      = 1'b0;
  logic              ld_we   = 1'b0;
  upd_mem_addr_t     ld_addr = '0;
  upd_map_entry_t    ld_data = '0;
  logic              pre     = 1'b0;
  logic              post    = 1'b0;
  logic [31:0]       rdata, secs;
  logic              waitreq, ack, req, dir, busy, done;
  logic [4:0]        slot;
  upd_map_entry_t    entry;
  logic [37:0]       seen[$];
  int                error_cnt = 0;
  int                samples_checked = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (req === 1'b1 && ack === 1'b1)
    seen.push_back({dir, slot, entry});
  upd_top #(.TICK_CYCLES(4)) i_dut (.CLK_IN(clk), .SRST_IN(srst),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(32'hFFFFFFFF), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq), .LOAD_WE_IN(ld_we),
    .LOAD_ADDR_IN(ld_addr), .LOAD_DATA_IN(ld_data), .PRE_RUN_IN(pre),
    .POST_RUN_IN(post), .XFER_ACK_IN(ack), .XFER_REQ_OUT(req),
    .XFER_DIR_OUT(dir), .XFER_SLOT_OUT(slot), .XFER_ENTRY_OUT(entry),
    .COPY_BUSY_OUT(busy), .COPY_DONE_OUT(done), .UPTIME_SECONDS_OUT(secs));
  upd_xfer_model i_img (.clk_in(clk), .srst_in(srst), .req_in(req),
    .ack_out(ack));
  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] idx,
                     input logic [7:0] sub, output logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= {idx, sub, 2'b00};
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task automatic rdv(input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] exp);
    logic [31:0] d;
    acc(1'b0, idx, sub, d);
    chk({6'h00, d}, {6'h00, exp});
  endtask
  task automatic load(input logic [1:0] t, input logic [3:0] s,
                      input logic [31:0] d);
    @(posedge clk);
    ld_we <= 1'b1;
    ld_addr <= {t, s};
    ld_data <= d;
    @(posedge clk);
    ld_we <= 1'b0;
  endtask
  task automatic run(input logic is_pre);
    int n;
    seen.delete();
    @(posedge clk);
    pre <= is_pre;
    post <= !is_pre;
    @(posedge clk);
    pre <= 1'b0;
    post <= 1'b0;
    repeat (3) @(posedge clk);
    post <= 1'b1;
    @(posedge clk);
    post <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      give_verdict();
    end
    repeat (5) @(posedge clk);
    chk({37'h0, busy}, 38'h0);
  endtask
  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    logic [31:0] d, m1;
    logic [15:0] tbl[3];
    int n;
    tbl = '{OBJ_INPUT_SEL, OBJ_OUTPUT_SEL, OBJ_BIDIR_SEL};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdv(OBJ_UPTIME_MS, SUB_COUNT, MS_OBJ_COUNT);
    rdv(OBJ_UPTIME_S, SUB_COUNT, UPTIME_RESET);
    foreach (tbl[i]) rdv(tbl[i], SUB_COUNT, TABLE_COUNT);
    rdv(16'h2311, SUB_COUNT, READ_ZERO);
    $display("test reset values done");
    for (int i = 0; i < 48; i++) load(2'(i / 16), 4'(i % 16), 32'h0);
    load(TBL_INPUT, 4'h0, E_IN);
    load(TBL_OUTPUT, 4'hF, E_OUT);
    load(TBL_BIDIR, 4'h3, E_BI);
    acc(1'b1, OBJ_INPUT_SEL, 8'h01, d);
    acc(1'b1, OBJ_OUTPUT_SEL, SUB_COUNT, d);
    rdv(OBJ_INPUT_SEL, 8'h01, E_IN);
    rdv(OBJ_OUTPUT_SEL, SUB_COUNT, TABLE_COUNT);
    rdv(OBJ_OUTPUT_SEL, SUB_LAST_ENTRY, E_OUT);
    rdv(OBJ_BIDIR_SEL, 8'h04, E_BI);
    rdv(OBJ_BIDIR_SEL, 8'h11, READ_ZERO);
    $display("test tables done");
    run(1'b1);
    chk(38'(seen.size()), 38'd2);
    chk(seen[0], {DIR_TO_IMAGE, 5'd0, E_IN});
    chk(seen[1], {DIR_TO_IMAGE, 5'd19, E_BI});
    run(1'b0);
    chk(38'(seen.size()), 38'd2);
    chk(seen[0], {DIR_FROM_IMAGE, 5'd15, E_OUT});
    chk(seen[1], {DIR_FROM_IMAGE, 5'd19, E_BI});
    $display("test copy passes done");
    acc(1'b0, OBJ_UPTIME_MS, SUB_MS_VALUE, m1);
    repeat (396) @(posedge clk);
    acc(1'b0, OBJ_UPTIME_MS, SUB_MS_VALUE, d);
    chk({6'h00, d - m1}, 38'd100);
    n = 0;
    while (secs !== 32'h1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      error_cnt++;
      give_verdict();
    end
    rdv(OBJ_UPTIME_S, SUB_COUNT, 32'h1);
    acc(1'b0, OBJ_UPTIME_MS, SUB_MS_VALUE, d);
    chk({6'h00, d / 4}, 38'd250);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    acc(1'b0, OBJ_UPTIME_MS, SUB_MS_VALUE, d);
    chk({6'h00, d / 4}, 38'd0);
    chk({6'h00, secs}, 38'd0);
    $display("test counters done");
    give_verdict();
  end
endmodule
